// file: rtl/channel_level_phase_config.sv
// Functional notes
// - amp level field is bits 7..2, 1 dB per code, 0..42 dB.
// - volume code zero mutes the channel output completely.
// - nonzero volume codes step 0.5 dB, code 1 is -100 dB.
// - volume code 201 is 0 dB; register resets to c9.
// - level trim is bits 7..4, 0.1 dB steps from -0.8 dB.
// - trim code 8 is zero offset and reset; low nibble reads zero.
// - delay trim delays by that many modulator cycles; zero none; resets zero.
`timescale 1ns/100ps
`default_nettype none
module channel_level_phase_config
    import chan_cfg_pkg::*;
#(
    parameter int SAMPLE_W = 24
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [7:0] ctrl_page,
    input wire logic [7:0] ctrl_addr,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic ctrl_rd,
    output logic [7:0] ctrl_rdata,
    output logic ctrl_rvalid,
    input wire logic mod_tick,
    input wire logic [SAMPLE_W-1:0] sample_in,
    output logic [SAMPLE_W-1:0] sample_out,
    output logic sample_valid,
    output logic [5:0] chan_one_amp_level,
    output logic chan_one_mute,
    output logic signed [9:0] chan_one_volume_half_db,
    output logic signed [4:0] chan_one_trim_tenth_db,
    output logic [7:0] chan_one_delay_cycles
);
    // register file
    logic [5:0] amp_r, amp_nxt;
    logic [7:0] vol_r, vol_nxt;
    logic [3:0] trim_r, trim_nxt;
    logic [7:0] dly_r, dly_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;

    function automatic logic hit(input logic [7:0] page,
                                 input logic [7:0] addr,
                                 input logic [7:0] ofs);
        hit = (page == PAGE_CFG) && (addr == ofs);
    endfunction : hit

    always_comb begin
        amp_nxt = amp_r;
        vol_nxt = vol_r;
        trim_nxt = trim_r;
        dly_nxt = dly_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        if (ctrl_wr) begin
            // reserved gain codes are kept as written
            if (hit(ctrl_page, ctrl_addr, OFS_GAIN)) begin
                amp_nxt = ctrl_wdata[AMP_MSB:AMP_LSB];
            end
            if (hit(ctrl_page, ctrl_addr, OFS_VOLUME)) begin
                vol_nxt = ctrl_wdata;
            end
            if (hit(ctrl_page, ctrl_addr, OFS_GAIN_TRIM)) begin
                trim_nxt = ctrl_wdata[TRIM_MSB:TRIM_LSB];
            end
            if (hit(ctrl_page, ctrl_addr, OFS_PHASE_TRIM)) begin
                dly_nxt = ctrl_wdata;
            end
        end
        if (ctrl_rd) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = ZERO_BYTE;
            if (hit(ctrl_page, ctrl_addr, OFS_GAIN)) begin
                rdata_nxt = {amp_r, 2'h0};
            end
            if (hit(ctrl_page, ctrl_addr, OFS_VOLUME)) begin
                rdata_nxt = vol_r;
            end
            if (hit(ctrl_page, ctrl_addr, OFS_GAIN_TRIM)) begin
                rdata_nxt = {trim_r, 4'h0};
            end
            if (hit(ctrl_page, ctrl_addr, OFS_PHASE_TRIM)) begin
                rdata_nxt = dly_r;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            amp_r <= RST_GAIN[AMP_MSB:AMP_LSB];
            vol_r <= RST_VOLUME;
            trim_r <= RST_GAIN_TRIM[TRIM_MSB:TRIM_LSB];
            dly_r <= RST_PHASE_TRIM;
            rdata_r <= ZERO_BYTE;
            rvalid_r <= 1'b0;
        end else if (clk_en) begin
            amp_r <= amp_nxt;
            vol_r <= vol_nxt;
            trim_r <= trim_nxt;
            dly_r <= dly_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign ctrl_rdata = rdata_r;
    assign ctrl_rvalid = rvalid_r;

    // decoded settings, registered so the consumers see clean levels
    logic mute_r, mute_nxt;
    logic signed [9:0] vhalf_r, vhalf_nxt;
    logic signed [4:0] tenth_r, tenth_nxt;

    always_comb begin
        mute_nxt = (vol_r == VOL_MUTE_CODE);
        // code minus 201 in half-dB: 1 -> -200, 255 -> +54
        vhalf_nxt = signed'({2'b00, vol_r}) -
                    signed'({1'b0, VOL_UNITY_CODE});
        tenth_nxt = signed'({1'b0, trim_r}) -
                    signed'(TRIM_ZERO_CODE);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mute_r <= 1'b0;
            vhalf_r <= '0;
            tenth_r <= '0;
        end else if (clk_en) begin
            mute_r <= mute_nxt;
            vhalf_r <= vhalf_nxt;
            tenth_r <= tenth_nxt;
        end
    end

    assign chan_one_amp_level = amp_r;
    assign chan_one_mute = mute_r;
    assign chan_one_volume_half_db = vhalf_r;
    assign chan_one_trim_tenth_db = tenth_r;
    assign chan_one_delay_cycles = dly_r;

    // phase delay line, one entry per modulator cycle
    logic [7:0] wptr_r, wptr_nxt;
    logic [SAMPLE_W-1:0] hold_r, hold_nxt;
    logic [SAMPLE_W-1:0] out_r, out_nxt;
    logic [SAMPLE_W-1:0] ram_q;
    logic tick_d_r, tick_d_nxt;
    logic bypass_r, bypass_nxt;
    logic [7:0] raddr;

    // reading wptr minus a nonzero code at the tick yields the sample from code ticks ago
    assign raddr = wptr_r - dly_r;

    delay_ram #(
        .WIDTH(SAMPLE_W),
        .ABITS(8)
    ) u_delay_ram (
        .clk(mclk),
        .ce(clk_en),
        .we(mod_tick),
        .waddr(wptr_r),
        .wdata(sample_in),
        .re(mod_tick),
        .raddr(raddr),
        .rdata(ram_q)
    );

    always_comb begin
        wptr_nxt = wptr_r;
        hold_nxt = hold_r;
        out_nxt = out_r;
        tick_d_nxt = mod_tick;
        bypass_nxt = bypass_r;
        if (mod_tick) begin
            wptr_nxt = wptr_r + 8'h01;
            hold_nxt = sample_in;
            // code zero must bypass: the ram would return the old word
            bypass_nxt = (dly_r == ZERO_BYTE);
        end
        if (tick_d_r) begin
            if (mute_r) begin
                out_nxt = '0;
            end else if (bypass_r) begin
                out_nxt = hold_r;
            end else begin
                out_nxt = ram_q;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wptr_r <= ZERO_BYTE;
            hold_r <= '0;
            out_r <= '0;
            tick_d_r <= 1'b0;
            bypass_r <= 1'b1;
            sample_valid <= 1'b0;
        end else if (clk_en) begin
            wptr_r <= wptr_nxt;
            hold_r <= hold_nxt;
            out_r <= out_nxt;
            tick_d_r <= tick_d_nxt;
            bypass_r <= bypass_nxt;
            sample_valid <= tick_d_r;
        end
    end

    assign sample_out = out_r;
endmodule : channel_level_phase_config
`default_nettype wire

// file: shared/chan_cfg_pkg.sv
`default_nettype none
package chan_cfg_pkg;
    localparam logic [7:0] PAGE_CFG = 8'h00;
    localparam logic [7:0] OFS_GAIN = 8'h3d;
    localparam logic [7:0] OFS_VOLUME = 8'h3e;
    localparam logic [7:0] OFS_GAIN_TRIM = 8'h3f;
    localparam logic [7:0] OFS_PHASE_TRIM = 8'h40;

    localparam logic [7:0] RST_GAIN = 8'h00;
    localparam logic [7:0] RST_VOLUME = 8'hc9;
    localparam logic [7:0] RST_GAIN_TRIM = 8'h80;
    localparam logic [7:0] RST_PHASE_TRIM = 8'h00;

    localparam int AMP_LSB = 2;
    localparam int AMP_MSB = 7;
    localparam int TRIM_LSB = 4;
    localparam int TRIM_MSB = 7;

    localparam logic [7:0] VOL_MUTE_CODE = 8'h00;
    localparam logic [8:0] VOL_UNITY_CODE = 9'h0c9;
    localparam logic [4:0] TRIM_ZERO_CODE = 5'h08;

    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage : chan_cfg_pkg
`default_nettype wire

// file: rtl/delay_ram.sv
`timescale 1ns/100ps
`default_nettype none
module delay_ram #(
    parameter int WIDTH = 24,
    parameter int ABITS = 8
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [ABITS-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic re,
    input wire logic [ABITS-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [0:(1<<ABITS)-1];

    // no reset on the array; contents before the first lap are don't-care
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
        if (ce && re) begin
            rdata <= mem[raddr];
        end
    end
endmodule : delay_ram
`default_nettype wire

// file: dv/cfg_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_chk
    import chan_cfg_pkg::*;
#(parameter int SAMPLE_W = 24) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [7:0] ctrl_page,
    input wire logic [7:0] ctrl_addr,
    input wire logic ctrl_rd,
    input wire logic [7:0] ctrl_rdata,
    input wire logic mod_tick,
    input wire logic [SAMPLE_W-1:0] sample_in,
    input wire logic [SAMPLE_W-1:0] sample_out,
    input wire logic sample_valid,
    input wire logic [5:0] chan_one_amp_level,
    input wire logic chan_one_mute,
    input wire logic signed [9:0] chan_one_volume_half_db,
    input wire logic signed [4:0] chan_one_trim_tenth_db,
    input wire logic [7:0] chan_one_delay_cycles
);
    // decoded outputs lag the register as read data does
    wire logic hit = ctrl_rd && clk_en && ctrl_page == PAGE_CFG;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    property p_amp; hit && ctrl_addr == OFS_GAIN |->
        ##1 ctrl_rdata[7:2] == chan_one_amp_level; endproperty
    a_amp: assert property (p_amp) else $error("amp");
    property p_glow; hit && ctrl_addr == OFS_GAIN |->
        ##1 ctrl_rdata[1:0] == 2'h0; endproperty
    a_glow: assert property (p_glow) else $error("glow");
    property p_mute; hit && ctrl_addr == OFS_VOLUME |->
        ##1 chan_one_mute == (ctrl_rdata == 8'h00); endproperty
    a_mute: assert property (p_mute) else $error("mute");
    property p_vol; hit && ctrl_addr == OFS_VOLUME |-> ##1
        chan_one_volume_half_db == 10'({2'h0, ctrl_rdata} - 10'h0c9);
    endproperty
    a_vol: assert property (p_vol) else $error("vol");
    property p_trim; hit && ctrl_addr == OFS_GAIN_TRIM |-> ##1
        chan_one_trim_tenth_db == 5'({1'b0, ctrl_rdata[7:4]} - 5'h08);
    endproperty
    a_trim: assert property (p_trim) else $error("trim");
    property p_tlow; hit && ctrl_addr == OFS_GAIN_TRIM |->
        ##1 ctrl_rdata[3:0] == 4'h0; endproperty
    a_tlow: assert property (p_tlow) else $error("tlow");
    property p_dly; hit && ctrl_addr == OFS_PHASE_TRIM |->
        ##1 chan_one_delay_cycles == ctrl_rdata; endproperty
    a_dly: assert property (p_dly) else $error("dly");
    property p_pass; mod_tick && clk_en && !chan_one_mute &&
        chan_one_delay_cycles == 8'h00 |->
        ##2 sample_valid && sample_out == $past(sample_in, 2); endproperty
    a_pass: assert property (p_pass) else $error("pass");
endmodule : cfg_chk
bind channel_level_phase_config cfg_chk #(.SAMPLE_W(SAMPLE_W))
    u_chk (.*);
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import chan_cfg_pkg::*;
;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic ctrl_wr = 1'b0;
    logic ctrl_rd = 1'b0;
    logic mod_tick = 1'b0;
    logic [7:0] ctrl_page = 8'h00;
    logic [7:0] ctrl_addr = 8'h00;
    logic [7:0] ctrl_wdata = 8'h00;
    logic [23:0] sample_in = 24'h00_0000;
    logic [7:0] ctrl_rdata, chan_one_delay_cycles;
    logic [23:0] sample_out;
    logic [5:0] chan_one_amp_level;
    logic chan_one_mute, ctrl_rvalid, sample_valid;
    logic signed [9:0] chan_one_volume_half_db;
    logic signed [4:0] chan_one_trim_tenth_db;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    channel_level_phase_config dut (.*);
    always #2.5 mclk = ~mclk;
    task automatic chk(input logic [23:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        @(posedge mclk);
        ctrl_addr <= a;
        ctrl_wdata <= d;
        ctrl_wr <= 1'b1;
        @(posedge mclk);
        ctrl_wr <= 1'b0;
    endtask : wr
    // read data holds, so sampling an edge late is safe
    task automatic rd(input logic [7:0] a, exp);
        @(posedge mclk);
        ctrl_addr <= a;
        ctrl_rd <= 1'b1;
        @(posedge mclk);
        ctrl_rd <= 1'b0;
        #1 chk(ctrl_rvalid, 1'b1);
        @(posedge mclk);
        #1 chk(ctrl_rdata, exp);
        chk(ctrl_rvalid, 1'b0);
    endtask : rd
    task automatic t_regs;
        logic [7:0] v[4] = '{8'h00, 8'h01, 8'h02, 8'hff};
        rd(OFS_GAIN, 8'h00);
        rd(OFS_VOLUME, 8'hc9);
        rd(OFS_GAIN_TRIM, 8'h80);
        chk(chan_one_trim_tenth_db, 0);
        rd(OFS_PHASE_TRIM, 8'h00);
        wr(OFS_GAIN, 8'hab);
        rd(OFS_GAIN, 8'ha8);
        chk(chan_one_amp_level, 42);
        wr(OFS_GAIN, 8'hff);
        rd(OFS_GAIN, 8'hfc);
        chk(chan_one_amp_level, 63);
        rd(8'h41, 8'h00);
        // other pages neither write nor read this bank
        @(posedge mclk);
        ctrl_page <= 8'h01;
        wr(OFS_GAIN, 8'h04);
        rd(OFS_GAIN, 8'h00);
        @(posedge mclk);
        ctrl_page <= 8'h00;
        rd(OFS_GAIN, 8'hfc);
        wr(OFS_GAIN_TRIM, 8'hff);
        rd(OFS_GAIN_TRIM, 8'hf0);
        chk(chan_one_trim_tenth_db, 7);
        wr(OFS_GAIN_TRIM, 8'h0f);
        rd(OFS_GAIN_TRIM, 8'h00);
        chk(chan_one_trim_tenth_db, -8);
        chk(chan_one_delay_cycles, 8'h00);
        foreach (v[i]) begin
            wr(OFS_VOLUME, v[i]);
            rd(OFS_VOLUME, v[i]);
            chk(chan_one_mute, v[i] == 8'h00);
            chk(chan_one_volume_half_db, int'(v[i]) - 201);
        end
        $display("register test end");
    endtask : t_regs
    task automatic t_path(input logic [7:0] d, vol);
        logic [23:0] e;
        wr(OFS_PHASE_TRIM, d);
        wr(OFS_VOLUME, vol);
        #1 chk(chan_one_delay_cycles, d);
        for (int k = 0; k < d + 3; k++) begin
            @(posedge mclk);
            mod_tick <= 1'b1;
            sample_in <= {16'h5a5a, 8'(k)};
            @(posedge mclk);
            mod_tick <= 1'b0;
            @(posedge mclk);
            e = vol == 8'h00 ? 24'h00_0000 : {16'h5a5a, 8'(k - d)};
            #1 chk(sample_valid, 1'b1);
            if (k >= d) chk(sample_out, e);
            @(posedge mclk);
            #1 chk(sample_valid, 1'b0);
        end
        $display("path test end");
    endtask : t_path
    // a write while the enable is low must leave no trace
    task automatic t_freeze;
        @(posedge mclk);
        clk_en <= 1'b0;
        wr(OFS_PHASE_TRIM, 8'h55);
        @(posedge mclk);
        clk_en <= 1'b1;
        rd(OFS_PHASE_TRIM, 8'h00);
        $display("freeze test end");
    endtask : t_freeze
    task automatic t_reset;
        wr(OFS_GAIN, 8'hff);
        wr(OFS_VOLUME, 8'h00);
        wr(OFS_GAIN_TRIM, 8'h00);
        wr(OFS_PHASE_TRIM, 8'h07);
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd(OFS_GAIN, 8'h00);
        rd(OFS_VOLUME, 8'hc9);
        rd(OFS_GAIN_TRIM, 8'h80);
        rd(OFS_PHASE_TRIM, 8'h00);
        chk(chan_one_amp_level, 0);
        chk(chan_one_mute, 1'b0);
        chk(chan_one_volume_half_db, 0);
        chk(chan_one_trim_tenth_db, 0);
        chk(chan_one_delay_cycles, 8'h00);
        chk(sample_out, 24'h00_0000);
        chk(sample_valid, 1'b0);
        $display("reset test end");
    endtask : t_reset
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        t_regs();
        t_freeze();
        t_path(8'h00, 8'hc9);
        t_path(8'h03, 8'hc9);
        t_path(8'hff, 8'hc9);
        t_path(8'h02, 8'h00);
        t_reset();
        summarize();
    end
endmodule : tb_top
`default_nettype wire
